/* File: hw/pfim_pkg.sv */
// Purpose: Constants and types for the fault interrupt masking block
// Assumes: Registers reached through a simple internal write/read port
// Notes: Overview below lists the behaviour the block keeps
// Overview of operation
// R01: Overcurrent mask bit 2 set keeps the interrupt line unchanged on regulator three overcurrent.
// R02: Overcurrent mask bit 1 set keeps the line unchanged on regulator two overcurrent.
// R03: Overcurrent mask bit 0 set keeps the line unchanged on regulator one overcurrent.
// R04: Thermal and undervoltage mask register sits at offset 0x1E, resets to zero.
// R05: Mask bit 7 set blocks thermal shutdown from the interrupt line.
// R06: Mask bit 6 set blocks thermal warning from the interrupt line.
// R07: Mask bit 5 set blocks system supply undervoltage lockout.
// R08: Mask bit 4 set blocks input seven undervoltage lockout.
// R09: Mask bit 3 set blocks input six undervoltage lockout.
// R10: Mask bit 2 set blocks input five undervoltage lockout.
// R11: Mask bit 1 set blocks shared input three-four undervoltage lockout.
// R12: Mask bit 0 set blocks shared input one-two undervoltage lockout.
// R13: Interrupt line low while any unmasked fault is pending, released otherwise.
package pfim_pkg;
	localparam logic [7:0] TUV_MASK_ADDR = 8'h1E;
	localparam logic [7:0] OC_MASK_ADDR = 8'h1D;
	localparam logic [7:0] PEND_ADDR_OC = 8'h1B;
	localparam logic [7:0] PEND_ADDR_TUV = 8'h1C;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam int TSD_BIT = 7;
	localparam int TWARN_BIT = 6;
	localparam int VSYS_BIT = 5;
	localparam int IN7_BIT = 4;
	localparam int IN6_BIT = 3;
	localparam int IN5_BIT = 2;
	localparam int IN34_BIT = 1;
	localparam int IN12_BIT = 0;
	localparam int OC3_BIT = 2;
	localparam int OC2_BIT = 1;
	localparam int OC1_BIT = 0;
	typedef struct packed {
		logic [7:0] overcurrent;
		logic [7:0] thermal_uv;
	} pfim_evt_type;
	typedef struct packed {
		logic [7:0] overcurrent_irq_mask;
		logic [7:0] thermal_undervoltage_irq_mask;
		logic [7:0] pend_oc;
		logic [7:0] pend_tuv;
		logic [7:0] rdata;
		logic irq_n;
	} pfim_state_type;
endpackage

/* File: hw/pfim_sync.sv */
// Purpose: Two flip-flop synchroniser for the fault event levels
// Assumes: Events arrive from analog comparators, asynchronous to sys_clk_i
// Notes: First stage is read only by the second
`timescale 1ns/100ps
module pfim_sync (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Events
	input wire pfim_pkg::pfim_evt_type async_i,
	output pfim_pkg::pfim_evt_type sync_o
);
	pfim_pkg::pfim_evt_type meta_q;
	pfim_pkg::pfim_evt_type sync_q;
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end
	assign sync_o = sync_q;
endmodule

/* File: hw/pfim_top.sv */
// Purpose: Masks fault events onto one open-drain active-low interrupt line
// Assumes: Event inputs are levels; pending bits clear on write-one to pending registers
// Notes: Interrupt pin given as output plus enable; it is never driven high
`timescale 1ns/100ps
module pfim_top (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Fault events
	input wire pfim_pkg::pfim_evt_type fault_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Interrupt pin
	output logic irq_n_o,
	output logic irq_n_oe_o
);
	pfim_pkg::pfim_evt_type evt;
	pfim_pkg::pfim_state_type s_q;
	pfim_pkg::pfim_state_type s_d;
	logic any_unmasked;

	pfim_sync u_sync (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.async_i(fault_i),
		.sync_o(evt)
	);

	function automatic logic [7:0] clr_set(input logic [7:0] pend, input logic [7:0] ev,
		input logic clr, input logic [7:0] w);
		// Set wins over a simultaneous clear
		clr_set = (pend & ~(clr ? w : 8'h00)) | ev;
	endfunction

	// Pending fault is visible on the line only while its mask bit is clear
	assign any_unmasked = |(s_q.pend_oc & ~s_q.overcurrent_irq_mask) // [R01] [R02] [R03]
		| |(s_q.pend_tuv & ~s_q.thermal_undervoltage_irq_mask); // [R05] [R06] [R07] [R08] [R09] [R10] [R11] [R12]

	// Next state: pending sets, write-one clears, mask writes and reads
	always_comb begin
		s_d = s_q;
		s_d.pend_oc = clr_set(s_q.pend_oc, evt.overcurrent,
			reg_wr_i && reg_addr_i == pfim_pkg::PEND_ADDR_OC, reg_wdata_i);
		s_d.pend_tuv = clr_set(s_q.pend_tuv, evt.thermal_uv,
			reg_wr_i && reg_addr_i == pfim_pkg::PEND_ADDR_TUV, reg_wdata_i);
		if (reg_wr_i && reg_addr_i == pfim_pkg::TUV_MASK_ADDR) begin
			s_d.thermal_undervoltage_irq_mask = reg_wdata_i; // [R04]
		end
		if (reg_wr_i && reg_addr_i == pfim_pkg::OC_MASK_ADDR) begin
			s_d.overcurrent_irq_mask = reg_wdata_i;
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				pfim_pkg::TUV_MASK_ADDR: s_d.rdata = s_q.thermal_undervoltage_irq_mask;
				pfim_pkg::OC_MASK_ADDR: s_d.rdata = s_q.overcurrent_irq_mask;
				pfim_pkg::PEND_ADDR_OC: s_d.rdata = s_q.pend_oc;
				pfim_pkg::PEND_ADDR_TUV: s_d.rdata = s_q.pend_tuv;
				default: s_d.rdata = 8'h00;
			endcase
		end
		s_d.irq_n = ~any_unmasked; // [R13]
	end

	// All state moves in one register stage
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			s_q.overcurrent_irq_mask <= pfim_pkg::MASK_RESET;
			s_q.thermal_undervoltage_irq_mask <= pfim_pkg::MASK_RESET; // [R04]
			s_q.pend_oc <= 8'h00;
			s_q.pend_tuv <= 8'h00;
			s_q.rdata <= 8'h00;
			s_q.irq_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o = s_q.rdata;
	assign irq_n_o = 1'b0;
	assign irq_n_oe_o = ~s_q.irq_n;

	// Per-source checks: open sources pull the line, masked ones leave it
	a_mask_reset: assert property (@(posedge sys_clk_i) reset_i |=> // [R04]
		s_q.thermal_undervoltage_irq_mask == 8'h00)
		else $error("mask register not zero after reset");
	a_oc3_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R01]
		(s_q.pend_oc == 8'h04 && s_q.overcurrent_irq_mask[2] && s_q.pend_tuv == 8'h00) |=> !irq_n_oe_o)
		else $error("masked overcurrent three drove line");
	a_oc2_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R02]
		(s_q.pend_oc == 8'h02 && s_q.overcurrent_irq_mask[1] && s_q.pend_tuv == 8'h00) |=> !irq_n_oe_o)
		else $error("masked overcurrent two drove line");
	a_oc1_live: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R03]
		(s_q.pend_oc[0] && !s_q.overcurrent_irq_mask[0]) |=> irq_n_oe_o)
		else $error("unmasked overcurrent one missed");
	a_tsd_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R05]
		(s_q.pend_tuv == 8'h80 && s_q.thermal_undervoltage_irq_mask[7] && s_q.pend_oc == 8'h00) |=> !irq_n_oe_o)
		else $error("masked shutdown drove line");
	a_twarn_live: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R06]
		(s_q.pend_tuv[6] && !s_q.thermal_undervoltage_irq_mask[6]) |=> irq_n_oe_o)
		else $error("unmasked warning missed");
	a_vsys_live: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R07]
		(s_q.pend_tuv[5] && !s_q.thermal_undervoltage_irq_mask[5]) |=> irq_n_oe_o)
		else $error("unmasked supply lockout missed");
	a_in7_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R08]
		(s_q.pend_tuv == 8'h10 && s_q.thermal_undervoltage_irq_mask[4] && s_q.pend_oc == 8'h00) |=> !irq_n_oe_o)
		else $error("masked input seven drove line");
	a_in6_live: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R09]
		(s_q.pend_tuv[3] && !s_q.thermal_undervoltage_irq_mask[3]) |=> irq_n_oe_o)
		else $error("unmasked input six missed");
	a_in5_live: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R10]
		(s_q.pend_tuv[2] && !s_q.thermal_undervoltage_irq_mask[2]) |=> irq_n_oe_o)
		else $error("unmasked input five missed");
	a_in34_live: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R11]
		(s_q.pend_tuv[1] && !s_q.thermal_undervoltage_irq_mask[1]) |=> irq_n_oe_o)
		else $error("unmasked input three-four missed");
	a_in12_live: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R12]
		(s_q.pend_tuv[0] && !s_q.thermal_undervoltage_irq_mask[0]) |=> irq_n_oe_o)
		else $error("unmasked input one-two missed");
	a_line_release: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R13]
		((s_q.pend_oc & ~s_q.overcurrent_irq_mask) == 8'h00
		&& (s_q.pend_tuv & ~s_q.thermal_undervoltage_irq_mask) == 8'h00) |=> !irq_n_oe_o)
		else $error("line held with nothing pending");
	a_event_latch: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R13]
		(fault_i.thermal_uv[7] && !s_q.thermal_undervoltage_irq_mask[7]) [*4] |=> irq_n_oe_o)
		else $error("shutdown did not reach line in time");
	a_event_latch_oc: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R01]
		(fault_i.overcurrent[2] && !s_q.overcurrent_irq_mask[2]) [*4] |=> irq_n_oe_o)
		else $error("overcurrent three did not reach line in time");

	// Other case of each source: open where the group above is masked, masked where it is open
	a_oc3_live: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R01]
		(s_q.pend_oc[2] && !s_q.overcurrent_irq_mask[2]) |=> irq_n_oe_o)
		else $error("unmasked overcurrent three missed");
	a_oc2_live: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R02]
		(s_q.pend_oc[1] && !s_q.overcurrent_irq_mask[1]) |=> irq_n_oe_o)
		else $error("unmasked overcurrent two missed");
	a_oc1_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R03]
		(s_q.pend_oc == 8'h01 && s_q.overcurrent_irq_mask[0] && s_q.pend_tuv == 8'h00) |=> !irq_n_oe_o)
		else $error("masked overcurrent one drove line");
	a_tsd_live: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R05]
		(s_q.pend_tuv[7] && !s_q.thermal_undervoltage_irq_mask[7]) |=> irq_n_oe_o)
		else $error("unmasked shutdown missed");
	a_twarn_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R06]
		(s_q.pend_tuv == 8'h40 && s_q.thermal_undervoltage_irq_mask[6] && s_q.pend_oc == 8'h00) |=> !irq_n_oe_o)
		else $error("masked warning drove line");
	a_vsys_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R07]
		(s_q.pend_tuv == 8'h20 && s_q.thermal_undervoltage_irq_mask[5] && s_q.pend_oc == 8'h00) |=> !irq_n_oe_o)
		else $error("masked supply lockout drove line");
	a_in7_live: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R08]
		(s_q.pend_tuv[4] && !s_q.thermal_undervoltage_irq_mask[4]) |=> irq_n_oe_o)
		else $error("unmasked input seven missed");
	a_in6_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R09]
		(s_q.pend_tuv == 8'h08 && s_q.thermal_undervoltage_irq_mask[3] && s_q.pend_oc == 8'h00) |=> !irq_n_oe_o)
		else $error("masked input six drove line");
	a_in5_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R10]
		(s_q.pend_tuv == 8'h04 && s_q.thermal_undervoltage_irq_mask[2] && s_q.pend_oc == 8'h00) |=> !irq_n_oe_o)
		else $error("masked input five drove line");
	a_in34_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R11]
		(s_q.pend_tuv == 8'h02 && s_q.thermal_undervoltage_irq_mask[1] && s_q.pend_oc == 8'h00) |=> !irq_n_oe_o)
		else $error("masked input three-four drove line");
	a_in12_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R12]
		(s_q.pend_tuv == 8'h01 && s_q.thermal_undervoltage_irq_mask[0] && s_q.pend_oc == 8'h00) |=> !irq_n_oe_o)
		else $error("masked input one-two drove line");

	// Pending bits: reset, set wins over clear, clear when quiet
	a_pend_reset: assert property (@(posedge sys_clk_i) reset_i |=> // [R13]
		s_q.pend_oc == 8'h00 && s_q.pend_tuv == 8'h00 && !irq_n_oe_o)
		else $error("pending or line not cleared by reset");
	a_set_wins_oc: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R13]
		(evt.overcurrent != 8'h00) |=> (s_q.pend_oc & $past(evt.overcurrent)) == $past(evt.overcurrent))
		else $error("overcurrent event lost");
	a_set_wins_tuv: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R13]
		(evt.thermal_uv != 8'h00) |=> (s_q.pend_tuv & $past(evt.thermal_uv)) == $past(evt.thermal_uv))
		else $error("thermal or undervoltage event lost");
	a_w1c_clear_oc: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R13]
		(reg_wr_i && reg_addr_i == pfim_pkg::PEND_ADDR_OC && evt.overcurrent == 8'h00)
		|=> (s_q.pend_oc & $past(reg_wdata_i)) == 8'h00)
		else $error("overcurrent pending not cleared");
	a_w1c_clear_tuv: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R13]
		(reg_wr_i && reg_addr_i == pfim_pkg::PEND_ADDR_TUV && evt.thermal_uv == 8'h00)
		|=> (s_q.pend_tuv & $past(reg_wdata_i)) == 8'h00)
		else $error("thermal or undervoltage pending not cleared");

	// Register port
	a_oc_mask_reset: assert property (@(posedge sys_clk_i) reset_i |=> // [R01]
		s_q.overcurrent_irq_mask == pfim_pkg::MASK_RESET)
		else $error("overcurrent mask not cleared by reset");
	a_tuv_write: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R04]
		(reg_wr_i && reg_addr_i == pfim_pkg::TUV_MASK_ADDR) |=> s_q.thermal_undervoltage_irq_mask == $past(reg_wdata_i))
		else $error("mask write lost");
	a_oc_write: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R01]
		(reg_wr_i && reg_addr_i == pfim_pkg::OC_MASK_ADDR) |=> s_q.overcurrent_irq_mask == $past(reg_wdata_i))
		else $error("overcurrent mask write lost");
	a_mask_read: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R04]
		(reg_rd_i && reg_addr_i == pfim_pkg::TUV_MASK_ADDR) |=> reg_rdata_o == $past(s_q.thermal_undervoltage_irq_mask))
		else $error("mask read wrong");
	a_oc_read: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R01]
		(reg_rd_i && reg_addr_i == pfim_pkg::OC_MASK_ADDR) |=> reg_rdata_o == $past(s_q.overcurrent_irq_mask))
		else $error("overcurrent mask read wrong");
	a_pend_read_oc: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R13]
		(reg_rd_i && reg_addr_i == pfim_pkg::PEND_ADDR_OC) |=> reg_rdata_o == $past(s_q.pend_oc))
		else $error("overcurrent pending read wrong");
	a_pend_read_tuv: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R13]
		(reg_rd_i && reg_addr_i == pfim_pkg::PEND_ADDR_TUV) |=> reg_rdata_o == $past(s_q.pend_tuv))
		else $error("thermal or undervoltage pending read wrong");
	a_unmapped_read: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R04]
		(reg_rd_i && reg_addr_i != pfim_pkg::TUV_MASK_ADDR && reg_addr_i != pfim_pkg::OC_MASK_ADDR
		&& reg_addr_i != pfim_pkg::PEND_ADDR_OC && reg_addr_i != pfim_pkg::PEND_ADDR_TUV) |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [R04]
		(!reg_rd_i) |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");

	c_irq_assert: cover property (@(posedge sys_clk_i) disable iff (reset_i) $rose(irq_n_oe_o));
	c_irq_release: cover property (@(posedge sys_clk_i) disable iff (reset_i) $fell(irq_n_oe_o));
	c_masked_pend: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		(s_q.pend_tuv != 8'h00) && !irq_n_oe_o);
	c_set_wins: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		reg_wr_i && reg_addr_i == pfim_pkg::PEND_ADDR_TUV && evt.thermal_uv != 8'h00);
	c_unmask_shows: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		$fell(s_q.thermal_undervoltage_irq_mask[7]) && s_q.pend_tuv[7]);
endmodule

/* File: verification/pfim_host_model.sv */
// Purpose: Host side of the interrupt line, resolving the open-drain pin
// Assumes: Board pull-up holds the line high when nothing pulls it down
// Notes: The host only sees the resolved pin level
`timescale 1ns/100ps
module pfim_host_model (
	// Pin from the block
	input wire logic irq_n_i,
	input wire logic irq_n_oe_i,
	// Resolved line
	output logic irq_pin_o
);
	// Released line floats to the pull-up level
	assign irq_pin_o = irq_n_oe_i ? irq_n_i : 1'b1;
endmodule

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the fault interrupt masking block
// Assumes: Host model resolves the open-drain line with a pull-up
// Notes: Every source is tried alone, masked and with only its own bit open in its mask register
`timescale 1ns/100ps
module tb_top;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	pfim_pkg::pfim_evt_type fault_i = '0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic irq_n_o;
	logic irq_n_oe_o;
	logic irq_pin;
	logic [7:0] rv;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [15:0] r_flt [22];
	logic [7:0] r_addr [22];
	logic [7:0] r_mask [22];
	logic r_pin [22];
	always #20 sys_clk_i = ~sys_clk_i;
	pfim_top uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .fault_i(fault_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o));
	pfim_host_model host (.irq_n_i(irq_n_o), .irq_n_oe_i(irq_n_oe_o), .irq_pin_o(irq_pin));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge sys_clk_i);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge sys_clk_i);
		reg_rd_i = 1'b0;
		@(negedge sys_clk_i);
		d = reg_rdata_o;
	endtask
	task automatic end_sim;
		if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		for (int i = 0; i < 22; i++) begin
			r_flt[i] = (i < 6) ? (16'h0100 << (i / 2)) : (16'h0001 << (i / 2 - 3));
			r_addr[i] = (i < 6) ? pfim_pkg::OC_MASK_ADDR : pfim_pkg::TUV_MASK_ADDR;
			r_mask[i] = (i < 6) ? (8'h01 << (i / 2)) : (8'h01 << (i / 2 - 3));
			r_pin[i] = i[0];
			if (!i[0]) r_mask[i] = ~r_mask[i];
		end
		repeat (6) @(negedge sys_clk_i);
		reset_i = 1'b0;
		rd(pfim_pkg::TUV_MASK_ADDR, rv);
		check("tuv mask reset", rv, 8'h00);
		rd(pfim_pkg::OC_MASK_ADDR, rv);
		check("oc mask reset", rv, 8'h00);
		wr(pfim_pkg::TUV_MASK_ADDR, 8'hA5);
		rd(pfim_pkg::TUV_MASK_ADDR, rv);
		check("tuv mask readback", rv, 8'hA5);
		wr(pfim_pkg::OC_MASK_ADDR, 8'h07);
		rd(pfim_pkg::OC_MASK_ADDR, rv);
		check("oc mask readback", rv, 8'h07);
		rd(8'h40, rv);
		check("unmapped read", rv, 8'h00);
		for (int i = 0; i < 22; i++) begin
			wr(r_addr[i], r_mask[i]);
			fault_i = r_flt[i];
			repeat (6) @(negedge sys_clk_i);
			check("irq pin", {7'h00, irq_pin}, {7'h00, r_pin[i]});
			fault_i = '0;
			repeat (5) @(negedge sys_clk_i);
			wr(pfim_pkg::PEND_ADDR_OC, 8'hFF);
			wr(pfim_pkg::PEND_ADDR_TUV, 8'hFF);
			repeat (3) @(negedge sys_clk_i);
			check("irq release", {7'h00, irq_pin}, 8'h01);
		end
		rd(pfim_pkg::PEND_ADDR_OC, rv);
		check("oc pending cleared", rv, 8'h00);
		rd(pfim_pkg::PEND_ADDR_TUV, rv);
		check("tuv pending cleared", rv, 8'h00);
		// Masked event stays latched and shows once unmasked
		wr(pfim_pkg::TUV_MASK_ADDR, 8'h80);
		fault_i = 16'h0080;
		repeat (6) @(negedge sys_clk_i);
		check("masked shutdown", {7'h00, irq_pin}, 8'h01);
		rd(pfim_pkg::PEND_ADDR_TUV, rv);
		check("masked shutdown latched", rv, 8'h80);
		wr(pfim_pkg::TUV_MASK_ADDR, 8'h00);
		repeat (3) @(negedge sys_clk_i);
		check("unmasked shutdown", {7'h00, irq_pin}, 8'h00);
		// Clear while the event still stands: the set wins
		wr(pfim_pkg::PEND_ADDR_TUV, 8'hFF);
		rd(pfim_pkg::PEND_ADDR_TUV, rv);
		check("pending set wins", rv, 8'h80);
		check("irq pin held", {7'h00, irq_pin}, 8'h00);
		check("irq drive value", {7'h00, irq_n_o}, 8'h00);
		wr(pfim_pkg::TUV_MASK_ADDR, 8'h3C);
		reset_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		reset_i = 1'b0;
		fault_i = '0;
		rd(pfim_pkg::TUV_MASK_ADDR, rv);
		check("tuv mask rereset", rv, 8'h00);
		check("irq pin after reset", {7'h00, irq_pin}, 8'h01);
		rd(pfim_pkg::PEND_ADDR_TUV, rv);
		check("pending after reset", rv, 8'h00);
		end_sim();
	end
endmodule
